// file: core/ses_pkg.sv
package ses_pkg;
  // event register bit positions
  localparam int unsigned BitOpc   = 0;
  localparam int unsigned BitQyErr = 2;
  localparam int unsigned BitDdErr = 3;
  localparam int unsigned BitExErr = 4;
  localparam int unsigned BitCmErr = 5;
  localparam int unsigned BitPwrOn = 7;
  // only these bits can ever latch; the rest read zero
  localparam logic [7:0] EventImplMask = 8'hBD;
  localparam logic [7:0] LatchReset    = 8'h00;
  // enable value at reset when power-on clear is selected
  localparam logic [7:0] EnableClrVal  = 8'h00;
  // host command codes
  typedef enum logic [2:0] {
    SES_CMD_NONE  = 3'b000,
    SES_CMD_ESE   = 3'b001,
    SES_CMD_ESEQ  = 3'b010,
    SES_CMD_ESRQ  = 3'b011,
    SES_CMD_CLS   = 3'b100
  } ses_cmd_t;
endpackage

// file: core/ses_edge_latch.sv
// rising-edge latch for one event bit, set wins over clear
module ses_edge_latch
  import ses_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic cond,
  input  wire logic clr,
  output logic      bitOut
);
  logic condQ_q, condQ_d;
  logic bit_q, bit_d;
  logic rise;

  //////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    condQ_d = cond;
    rise    = cond & ~condQ_q;
    bit_d   = bit_q;
    if (clr) begin
      bit_d = 1'b0;
    end
    if (rise) begin
      bit_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      condQ_q <= 1'b0;
      bit_q   <= 1'b0;
    end else begin
      condQ_q <= condQ_d;
      bit_q   <= bit_d;
    end
  end

  assign bitOut = bit_q;

  hold_on_rise_a: assert property (
    @(posedge clk) disable iff (rst)
    (cond && !condQ_q) |=> bit_q)
    else $error("event rise lost");

endmodule

// file: core/ses_regs.sv
// Notes on behaviour
// - set-enable loads 8-bit value 0..255
// - enabled events ORed into summary bit
// - summary high only on enabled set bit
// - enable query returns enable register
// - event query returns latched event register
// - event query clears after capture
// - bits latch on condition rise
// - only read, clear-status or reset releases bits
// - enable reset value follows power-on clear
// - fixed bit map, unused bits zero
module ses_regs
  import ses_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       pwrOnClear,
  input  wire ses_cmd_t   cmd,
  input  wire logic [7:0] cmdValue,
  input  wire logic       opcCond,
  input  wire logic       queryErrCond,
  input  wire logic       devErrCond,
  input  wire logic       execErrCond,
  input  wire logic       cmdErrCond,
  input  wire logic       powerOnCond,
  output logic [7:0]      respData,
  output logic            respValid,
  output logic            eventSummary
);
  logic [7:0] enable_q, enable_d;
  logic [7:0] resp_q, resp_d;
  logic       respV_q, respV_d;
  logic       sum_q, sum_d;
  logic [7:0] conds;
  logic [7:0] latchBits;
  logic       clrEv;

  //////////////////////////////////////////////////////////////////////////
  // map conditions onto fixed positions
  always_comb begin
    conds           = 8'h00;
    conds[BitOpc]   = opcCond;
    conds[BitQyErr] = queryErrCond;
    conds[BitDdErr] = devErrCond;
    conds[BitExErr] = execErrCond;
    conds[BitCmErr] = cmdErrCond;
    conds[BitPwrOn] = powerOnCond;
  end

  // capture happens this cycle, clear lands after
  assign clrEv = (cmd == SES_CMD_ESRQ) || (cmd == SES_CMD_CLS);

  //////////////////////////////////////////////////////////////////////////
  // event latches; unused positions never instantiate a latch
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : gLatch
      if (EventImplMask[gi]) begin : gUsed
        ses_edge_latch uLatch (
          .clk    (clk),
          .rst    (rst),
          .cond   (conds[gi]),
          .clr    (clrEv),
          .bitOut (latchBits[gi])
        );
      end else begin : gZero
        assign latchBits[gi] = 1'b0;
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // command handling and summary
  always_comb begin
    enable_d = enable_q;
    resp_d   = resp_q;
    respV_d  = 1'b0;
    case (cmd)
      SES_CMD_ESE: begin
        enable_d = cmdValue;
      end
      SES_CMD_ESEQ: begin
        resp_d  = enable_q;
        respV_d = 1'b1;
      end
      SES_CMD_ESRQ: begin
        resp_d  = latchBits;
        respV_d = 1'b1;
      end
      default: begin
      end
    endcase
    // high only with an enabled set bit
    sum_d = |(latchBits & enable_q);
  end

  // enable keeps its content over reset unless power-on clear is set;
  // the host must select the clear on the very first reset
  // power-on clear choice
  always_ff @(posedge clk) begin
    if (rst) begin
      resp_q   <= LatchReset;
      respV_q  <= 1'b0;
      sum_q    <= 1'b0;
      if (pwrOnClear) begin
        enable_q <= EnableClrVal;
      end
    end else begin
      enable_q <= enable_d;
      resp_q   <= resp_d;
      respV_q  <= respV_d;
      sum_q    <= sum_d;
    end
  end

  assign respData     = resp_q;
  assign respValid    = respV_q;
  assign eventSummary = sum_q;

  //////////////////////////////////////////////////////////////////////////
  // checks
  summary_or_a: assert property (
    @(posedge clk) disable iff (rst)
    eventSummary == $past(|(latchBits & enable_q)))
    else $error("summary mismatch");

  summary_cause_a: assert property (
    @(posedge clk) disable iff (rst)
    (eventSummary && !$past(rst)) |-> $past(|latchBits))
    else $error("summary without event");

  enable_load_a: assert property (
    @(posedge clk) disable iff (rst)
    cmd == SES_CMD_ESE |=> enable_q == $past(cmdValue))
    else $error("enable not loaded");

  enable_query_a: assert property (
    @(posedge clk) disable iff (rst)
    cmd == SES_CMD_ESEQ |=> respValid && respData == $past(enable_q))
    else $error("enable query wrong");

  event_query_a: assert property (
    @(posedge clk) disable iff (rst)
    cmd == SES_CMD_ESRQ |=> respValid && respData == $past(latchBits))
    else $error("event query wrong");

  read_clear_a: assert property (
    @(posedge clk) disable iff (rst)
    (clrEv && conds == 8'h00) |=> latchBits == 8'h00)
    else $error("event not cleared");

  cls_enable_a: assert property (
    @(posedge clk) disable iff (rst)
    cmd == SES_CMD_CLS |=> enable_q == $past(enable_q))
    else $error("clear touched enable");

  bit_map_a: assert property (
    @(posedge clk) disable iff (rst)
    (latchBits & ~EventImplMask) == 8'h00)
    else $error("unused bit set");

  latch_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    !clrEv |=> (latchBits & $past(latchBits)) == $past(latchBits))
    else $error("bit released early");

endmodule

// file: dv/ses_host_model.sv
// host side: one command per call, released a cycle later
module ses_host_model
  import ses_pkg::*;
(
  input  wire logic clk,
  output ses_cmd_t   cmd,
  output logic [7:0] cmdValue
);
  timeunit 1ns;
  timeprecision 1ns;
  initial cmd = SES_CMD_NONE;
  initial cmdValue = 8'h00;
  // weight sum
  // caller passes the summed 2**n weights; idle value is inverted
  task automatic sendCmd(input ses_cmd_t c, input logic [7:0] v);
    @(negedge clk);
    cmd = c;
    cmdValue = v;
    @(negedge clk);
    cmd = SES_CMD_NONE;
    cmdValue = ~v;
  endtask
endmodule

// file: dv/standard_event_status_regs_bench.sv
module standard_event_status_regs_bench;
  import ses_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       pwrOnClear = 1'b1;
  logic [5:0] cond = 6'h00;
  ses_cmd_t   cmd;
  logic [7:0] cmdValue;
  logic [7:0] respData;
  logic       respValid;
  logic       eventSummary;
  int         errors = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  //////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      give_verdict();
    end
  end
  ses_host_model host_u (.clk(clk), .cmd(cmd), .cmdValue(cmdValue));
  ses_regs dut_u (
    .clk(clk), .rst(rst), .pwrOnClear(pwrOnClear), .cmd(cmd),
    .cmdValue(cmdValue), .opcCond(cond[0]), .queryErrCond(cond[1]),
    .devErrCond(cond[2]), .execErrCond(cond[3]), .cmdErrCond(cond[4]),
    .powerOnCond(cond[5]), .respData(respData), .respValid(respValid),
    .eventSummary(eventSummary)
  );
  //////////////////////////////////////////////////////////////////////
  // shared compare and query tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // answer lands on the taking edge, checked at the next falling edge
  task automatic query(input ses_cmd_t c, input logic [7:0] exp);
    host_u.sendCmd(c, 8'h00);
    // respValid stands only until the next rising edge
    check({7'h00, respValid}, 8'h01);
    check(respData, exp);
  endtask
  task automatic give_verdict();
    $display("done: %0d mismatches in %0d checks", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    pwrOnClear = 1'b0;
    query(SES_CMD_ESEQ, 8'h00);
    query(SES_CMD_ESRQ, 8'h00);
    $display("test reset done");
    host_u.sendCmd(SES_CMD_ESE, 8'h65);
    query(SES_CMD_ESEQ, 8'h65);
    host_u.sendCmd(SES_CMD_ESE, 8'hFF);
    query(SES_CMD_ESEQ, 8'hFF);
    $display("test enable done");
    cond = 6'h3F;
    repeat (3) @(negedge clk);
    cond = 6'h00;
    repeat (2) @(negedge clk);
    query(SES_CMD_ESRQ, 8'hBD);
    query(SES_CMD_ESRQ, 8'h00);
    $display("test latch done");
    host_u.sendCmd(SES_CMD_ESE, 8'h20);
    cond = 6'h10;
    repeat (3) @(negedge clk);
    check({7'h00, eventSummary}, 8'h01);
    host_u.sendCmd(SES_CMD_ESE, 8'h02);
    repeat (2) @(negedge clk);
    check({7'h00, eventSummary}, 8'h00);
    host_u.sendCmd(SES_CMD_CLS, 8'h00);
    query(SES_CMD_ESEQ, 8'h02);
    query(SES_CMD_ESRQ, 8'h00);
    $display("test summary done");
    cond = 6'h00;
    // rise lands on the same edge that takes the read
    fork
      host_u.sendCmd(SES_CMD_ESRQ, 8'h00);
      begin
        @(negedge clk);
        cond = 6'h01;
      end
    join
    check(respData, 8'h00);
    repeat (2) @(negedge clk);
    query(SES_CMD_ESRQ, 8'h01);
    $display("test collision done");
    // mid-run reset keeps enable, then one with clear selected
    cond = 6'h00;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    query(SES_CMD_ESEQ, 8'h02);
    query(SES_CMD_ESRQ, 8'h00);
    pwrOnClear = 1'b1;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    pwrOnClear = 1'b0;
    query(SES_CMD_ESEQ, 8'h00);
    $display("test reset keep done");
    give_verdict();
  end
endmodule
